// file: rtl/ocg_calibration.sv
// Sample FIFO and per-channel offset/gain calibration datapath
`default_nettype none

// -----------------------------------------------------------------
// Sample FIFO
// -----------------------------------------------------------------
module ocg_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [DEPTH-1:0][WIDTH-1:0] mem;
  logic [DEPTH-1:0][WIDTH-1:0] next_mem;
  logic [PW-1:0]               wrPtr;
  logic [PW-1:0]               next_wrPtr;
  logic [PW-1:0]               rdPtr;
  logic [PW-1:0]               next_rdPtr;
  logic [CW-1:0]               count;
  logic [CW-1:0]               next_count;
  logic                        push;
  logic                        pop;

  assign inReady  = (count != CW'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_comb begin
    next_mem   = mem;
    next_wrPtr = wrPtr;
    next_rdPtr = rdPtr;
    next_count = count;
    if (push) begin
      next_mem[wrPtr] = inData;
      next_wrPtr      = (wrPtr == PW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    end
    if (pop) begin
      next_rdPtr = (rdPtr == PW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
      count <= next_count;
    end
    mem <= next_mem;
  end
endmodule : ocg_fifo

// -----------------------------------------------------------------
// Calibration top
// -----------------------------------------------------------------
// Overview of operation
// - Under serial control the chop rate is modulator rate /32 or /8.
// - Under pin-strap control the chop rate is fixed at /32.
// - Offset and gain adjustment exist only under serial control.
// - Each channel keeps a signed 24-bit offset in three byte registers.
// - Offset is subtracted before the gain is applied.
// - At gain 0x555555 one offset count moves the output by -4/3 LSB.
// - Reset restores every offset to its factory value.
// - Each channel keeps a 24-bit gain in three bytes, factory 0x555555.
// - Software gain writes replace the factory value until reset.
// - Output is (raw - offset) * gain/4 * 4194300 / 2^42.
// - One gain count is about 0.23841835 ppm of scaling.
// - Inputs are filtered results at modulator rate over decimation.
module ocg_calibration (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        serialCtrl,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  output logic      [5:0]  chopDivisor,
  input  wire logic        rawValid,
  output logic             rawReady,
  input  wire logic [2:0]  rawChan,
  input  wire logic [23:0] rawData,
  output logic             outValid,
  input  wire logic        outReady,
  output logic      [2:0]  outChan,
  output logic      [23:0] outData
);
  localparam int N = ocg_pkg::NUM_CH;

  typedef logic [N-1:0][23:0] ocg_coef_t;

  ocg_coef_t   stgOff;
  ocg_coef_t   next_stgOff;
  ocg_coef_t   stgGain;
  ocg_coef_t   next_stgGain;
  ocg_coef_t   actOff;
  ocg_coef_t   next_actOff;
  ocg_coef_t   actGain;
  ocg_coef_t   next_actGain;
  logic        chopSel;
  logic        next_chopSel;
  logic [7:0]  next_regRdData;
  logic        next_outValid;
  logic [2:0]  next_outChan;
  logic [23:0] next_outData;
  logic        coefHit;
  logic [2:0]  wCh;
  logic [2:0]  wField;
  logic        headValid;
  logic [26:0] headWord;
  logic [2:0]  headChan;
  logic [23:0] headRaw;
  logic [23:0] selOff;
  logic [23:0] selGain;
  logic        adv;
  logic        pop;

  // ---------------------------------------------------------------
  // Arithmetic
  // ---------------------------------------------------------------
  function automatic logic [23:0] calc(input logic [23:0] raw,
                                       input logic [23:0] off,
                                       input logic [23:0] gain);
    logic signed [24:0] diff;
    logic signed [49:0] prodG;
    logic signed [73:0] prodK;
    logic signed [29:0] shifted;
    diff    = 25'($signed(raw)) - 25'($signed(off));
    prodG   = 50'(diff) * 50'($signed({1'b0, gain}));
    prodK   = 74'(prodG) * 74'($signed({1'b0, ocg_pkg::SCALE_K}));
    prodK   = prodK + $signed(ocg_pkg::SCALE_ROUND);
    shifted = 30'(prodK >>> ocg_pkg::SCALE_SHIFT);
    if (shifted > ocg_pkg::OUT_MAX) begin
      shifted = ocg_pkg::OUT_MAX;
    end else if (shifted < ocg_pkg::OUT_MIN) begin
      shifted = ocg_pkg::OUT_MIN;
    end
    return shifted[23:0];
  endfunction : calc

  function automatic logic [7:0] byteOf(input logic [23:0] v,
                                        input logic [1:0]  idx);
    return v[8*idx +: 8];
  endfunction : byteOf

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  assign wCh     = regAddr[5:3];
  assign wField  = regAddr[2:0];
  assign coefHit = (regAddr[7:6] == ocg_pkg::ADDR_CH_AREA)
                   && (wField <= ocg_pkg::F_GAIN_LO);

  always_comb begin
    next_stgOff    = stgOff;
    next_stgGain   = stgGain;
    next_actOff    = actOff;
    next_actGain   = actGain;
    next_chopSel   = chopSel;
    next_regRdData = regRdData;
    // writes honoured only under serial control
    if (regWrite && serialCtrl && coefHit) begin
      unique case (wField)
        ocg_pkg::F_OFF_HI:   next_stgOff[wCh][23:16]  = regWrData;
        ocg_pkg::F_OFF_MID:  next_stgOff[wCh][15:8]   = regWrData;
        ocg_pkg::F_OFF_LO:   next_stgOff[wCh][7:0]    = regWrData;
        ocg_pkg::F_GAIN_HI:  next_stgGain[wCh][23:16] = regWrData;
        ocg_pkg::F_GAIN_MID: next_stgGain[wCh][15:8]  = regWrData;
        default:             next_stgGain[wCh][7:0]   = regWrData;
      endcase
      if (wField == ocg_pkg::F_OFF_LO) begin
        next_actOff[wCh] = {stgOff[wCh][23:8], regWrData};
      end
      if (wField == ocg_pkg::F_GAIN_LO) begin
        next_actGain[wCh] = {stgGain[wCh][23:8], regWrData};
      end
    end
    if (regWrite && serialCtrl && regAddr == ocg_pkg::ADDR_CTRL) begin
      next_chopSel = regWrData[ocg_pkg::CTRL_CHOP];
    end
    if (regRead) begin
      next_regRdData = ocg_pkg::RD_UNMAPPED;
      if (coefHit) begin
        unique case (wField)
          ocg_pkg::F_OFF_HI:   next_regRdData = byteOf(stgOff[wCh], 2'h2);
          ocg_pkg::F_OFF_MID:  next_regRdData = byteOf(stgOff[wCh], 2'h1);
          ocg_pkg::F_OFF_LO:   next_regRdData = byteOf(stgOff[wCh], 2'h0);
          ocg_pkg::F_GAIN_HI:  next_regRdData = byteOf(stgGain[wCh], 2'h2);
          ocg_pkg::F_GAIN_MID: next_regRdData = byteOf(stgGain[wCh], 2'h1);
          default:             next_regRdData = byteOf(stgGain[wCh], 2'h0);
        endcase
      end else if (regAddr == ocg_pkg::ADDR_CTRL) begin
        next_regRdData[ocg_pkg::CTRL_CHOP] = chopSel;
      end else if (regAddr == ocg_pkg::ADDR_STATUS) begin
        next_regRdData[ocg_pkg::STAT_SERIAL] = serialCtrl;
        next_regRdData[ocg_pkg::STAT_PEND]   = headValid;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stgOff    <= {N{ocg_pkg::FACT_OFFSET}};
      actOff    <= {N{ocg_pkg::FACT_OFFSET}};
      stgGain   <= {N{ocg_pkg::FACT_GAIN}};
      actGain   <= {N{ocg_pkg::FACT_GAIN}};
      chopSel   <= ocg_pkg::RST_CTRL[ocg_pkg::CTRL_CHOP];
      regRdData <= '0;
    end else begin
      stgOff    <= next_stgOff;
      actOff    <= next_actOff;
      stgGain   <= next_stgGain;
      actGain   <= next_actGain;
      chopSel   <= next_chopSel;
      regRdData <= next_regRdData;
    end
  end

  // pin-strap forces the slow chop rate
  assign chopDivisor = (serialCtrl && chopSel) ? ocg_pkg::CHOP_FAST
                                               : ocg_pkg::CHOP_SLOW;

  // ---------------------------------------------------------------
  // Sample path
  // ---------------------------------------------------------------
  // decimated results are queued as they arrive
  ocg_fifo #(
    .WIDTH (27),
    .DEPTH (ocg_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .inValid  (rawValid),
    .inReady  (rawReady),
    .inData   ({rawChan, rawData}),
    .outValid (headValid),
    .outReady (adv),
    .outData  (headWord)
  );

  assign headChan = headWord[26:24];
  assign headRaw  = headWord[23:0];
  assign adv      = !outValid || outReady;
  assign pop      = headValid && adv;
  assign selOff   = serialCtrl ? actOff[headChan] : ocg_pkg::FACT_OFFSET;
  assign selGain  = serialCtrl ? actGain[headChan] : ocg_pkg::FACT_GAIN;

  always_comb begin
    next_outValid = outValid && !outReady;
    next_outChan  = outChan;
    next_outData  = outData;
    if (pop) begin
      next_outValid = 1'b1;
      next_outChan  = headChan;
      next_outData  = calc(headRaw, selOff, selGain);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      outValid <= 1'b0;
      outChan  <= '0;
      outData  <= '0;
    end else begin
      outValid <= next_outValid;
      outChan  <= next_outChan;
      outData  <= next_outData;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_chop_fast;
    @(posedge ref_clk) disable iff (rst)
    serialCtrl && regWrite && regAddr == ocg_pkg::ADDR_CTRL
      && regWrData[ocg_pkg::CTRL_CHOP] ##1 serialCtrl
      |-> chopDivisor == 6'h08;
  endproperty
  a_chop_fast: assert property (p_chop_fast)
    else $error("chop rate not /8 after select");

  property p_chop_pin;
    @(posedge ref_clk) disable iff (rst)
    !serialCtrl |-> chopDivisor == 6'h20;
  endproperty
  a_chop_pin: assert property (p_chop_pin)
    else $error("pin-strap chop rate not /32");

  property p_pin_locked;
    @(posedge ref_clk) disable iff (rst)
    !serialCtrl && regWrite |=> $stable(actOff) && $stable(actGain);
  endproperty
  a_pin_locked: assert property (p_pin_locked)
    else $error("coefficient changed under pin-strap");

  property p_off_step;
    @(posedge ref_clk) disable iff (rst)
    pop && headRaw == 24'h000000 && selOff == 24'h000064
      && selGain == 24'h555555 |=> outData == 24'hffff7b;
  endproperty
  a_off_step: assert property (p_off_step)
    else $error("offset step of 100 did not give -133");

  property p_zero_in;
    @(posedge ref_clk) disable iff (rst)
    pop && headRaw == selOff |=> outValid && outData == 24'h000000;
  endproperty
  a_zero_in: assert property (p_zero_in)
    else $error("offset not removed before gain");

  property p_factory;
    @(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> actOff == {N{24'h000000}}
      && actGain == {N{24'h555555}};
  endproperty
  a_factory: assert property (p_factory)
    else $error("factory coefficients not restored");

  property p_gain_commit;
    @(posedge ref_clk) disable iff (rst)
    serialCtrl && regWrite && coefHit && wField == ocg_pkg::F_GAIN_LO
      |=> actGain[$past(wCh)]
        == {$past(stgGain[wCh][23:8]), $past(regWrData)};
  endproperty
  a_gain_commit: assert property (p_gain_commit)
    else $error("gain low byte did not commit");

  property p_no_early;
    @(posedge ref_clk) disable iff (rst)
    regWrite && wField != ocg_pkg::F_GAIN_LO
      && wField != ocg_pkg::F_OFF_LO |=> $stable(actGain) && $stable(actOff);
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("coefficient changed before low byte");

  property p_hold;
    @(posedge ref_clk) disable iff (rst)
    outValid && !outReady |=> outValid && $stable(outData)
      && $stable(outChan);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed while stalled");

endmodule : ocg_calibration

`default_nettype wire

// file: rtl/ocg_pkg.sv
// Constants shared by the channel offset and gain calibration block
`default_nettype none

package ocg_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int NUM_CH     = 8;
  localparam int CH_W       = 3;
  localparam int DATA_W     = 24;
  localparam int FIFO_DEPTH = 8;

  // ---------------------------------------------------------------
  // Register map: channel area is {2'b00, channel, field}
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_CH_AREA = 2'h0;
  localparam logic [2:0] F_OFF_HI     = 3'h0;
  localparam logic [2:0] F_OFF_MID    = 3'h1;
  localparam logic [2:0] F_OFF_LO     = 3'h2;
  localparam logic [2:0] F_GAIN_HI    = 3'h3;
  localparam logic [2:0] F_GAIN_MID   = 3'h4;
  localparam logic [2:0] F_GAIN_LO    = 3'h5;
  localparam logic [7:0] ADDR_CTRL    = 8'h40;
  localparam logic [7:0] ADDR_STATUS  = 8'h41;
  localparam int         CTRL_CHOP    = 0;
  localparam int         STAT_SERIAL  = 0;
  localparam int         STAT_PEND    = 1;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;

  // ---------------------------------------------------------------
  // Factory coefficients and chop divisors
  // ---------------------------------------------------------------
  localparam logic [23:0] FACT_OFFSET = 24'h000000;
  localparam logic [23:0] FACT_GAIN   = 24'h555555;
  localparam logic [5:0]  CHOP_SLOW   = 6'h20;
  localparam logic [5:0]  CHOP_FAST   = 6'h08;

  // ---------------------------------------------------------------
  // Transfer: out = (raw - off) * gain / 4 * SCALE_K / 2^42
  // ---------------------------------------------------------------
  localparam logic [23:0] SCALE_K     = 24'h3ffffc;
  localparam int          SCALE_SHIFT = 44;
  localparam logic [73:0] SCALE_ROUND = 74'h800_0000_0000;
  localparam logic signed [29:0] OUT_MAX = 30'sh007f_ffff;
  localparam logic signed [29:0] OUT_MIN = -30'sh0080_0000;

endpackage : ocg_pkg

`default_nettype wire

// file: testbench/test_channel_offset_gain_calibration.sv
// Self-checking bench for the calibration block
`default_nettype none

module test_channel_offset_gain_calibration;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        ref_clk, rst, serialCtrl, regWrite, regRead;
  logic [7:0]  regAddr, regWrData, regRdData;
  logic [5:0]  chopDivisor;
  logic        rawValid, rawReady, outValid, outReady, holdOut;
  logic [2:0]  rawChan, outChan;
  logic [23:0] rawData, outData;
  logic [23:0] offM [8];
  logic [23:0] gainM [8];
  logic [26:0] expQ [$];
  logic [26:0] e;
  int          miscompares, cmp_count, cycles;

  ocg_calibration u_dut (
    .ref_clk(ref_clk), .rst(rst), .serialCtrl(serialCtrl),
    .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData),
    .chopDivisor(chopDivisor), .rawValid(rawValid), .rawReady(rawReady),
    .rawChan(rawChan), .rawData(rawData), .outValid(outValid),
    .outReady(outReady), .outChan(outChan), .outData(outData)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Expectation and comparison
  // ---------------------------------------------------------------
  function automatic logic [23:0] calc(logic [23:0] raw, logic [23:0] off,
                                       logic [23:0] gain);
    logic signed [79:0] p;
    p = $signed({{56{raw[23]}}, raw}) - $signed({{56{off[23]}}, off});
    p = p * $signed({56'h0, gain}) * 80'sd4194300;
    p = (p + (80'sd1 <<< 43)) >>> 44;
    if (p > 80'sd8388607) return 24'h7fffff;
    if (p < -80'sd8388608) return 24'h800000;
    return p[23:0];
  endfunction : calc

  task automatic chkByte(input string n, input logic [7:0] x,
                         input logic [7:0] g);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chkByte

  task automatic chkWord(input string n, input logic [26:0] x,
                         input logic [26:0] g);
    cmp_count++;
    if (g !== x) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask : chkWord

  task automatic end_of_test;
    if (expQ.size() != 0) begin
      miscompares++;
      $display("ERROR pending expected 0 seen %0d", expQ.size());
    end
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // Output side: random stalls, in-order checking, timeout
  // ---------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles++;
    outReady <= !holdOut && ($urandom_range(3) != 0);
    if (!rst && outValid === 1'b1 && outReady === 1'b1) begin
      if (expQ.size() == 0) begin
        miscompares++;
        $display("ERROR sample expected none seen %h", {outChan, outData});
      end else begin
        e = expQ.pop_front();
        chkWord("sample", e, {outChan, outData});
      end
    end
    if (cycles > 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWrite <= 1'b0;
    @(posedge ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x, input string n);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    chkByte(n, x, regRdData);
  endtask : rd

  task automatic setCoef(input logic [2:0] ch, input logic g,
                         input logic [23:0] v);
    logic [2:0] b;
    b = g ? 3'h3 : 3'h0;
    wr({2'b00, ch, b}, v[23:16]);
    wr({2'b00, ch, b + 3'h1}, v[15:8]);
    wr({2'b00, ch, b + 3'h2}, v[7:0]);
    if (serialCtrl && g) gainM[ch] = v;
    if (serialCtrl && !g) offM[ch] = v;
  endtask : setCoef

  task automatic send(input logic [2:0] ch, input logic [23:0] d);
    int n;
    n = 0;
    rawValid <= 1'b1;
    rawChan <= ch;
    rawData <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rawReady !== 1'b1 && n < 64);
    if (rawReady !== 1'b1) begin
      miscompares++;
      $display("ERROR rawReady expected 1 seen %b", rawReady);
    end
    expQ.push_back({ch, calc(d, serialCtrl ? offM[ch] : 24'h0,
                             serialCtrl ? gainM[ch] : 24'h555555)});
  endtask : send

  task automatic flush;
    int n;
    n = 0;
    rawValid <= 1'b0;
    while (expQ.size() != 0 && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (expQ.size() != 0) begin
      miscompares++;
      $display("ERROR flush expected 0 seen %0d", expQ.size());
    end
    @(posedge ref_clk);
  endtask : flush

  task automatic stream(input int n);
    for (int i = 0; i < n; i++) send(3'($urandom_range(7)), 24'($urandom));
    flush();
  endtask : stream

  task automatic factory;
    for (int i = 0; i < 8; i++) begin
      offM[i] = 24'h0;
      gainM[i] = 24'h555555;
    end
  endtask : factory

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    holdOut = 1'b0;
    factory();
    void'($urandom(15));
    rst <= 1'b1;
    serialCtrl <= 1'b1;
    regWrite <= 1'b0;
    regRead <= 1'b0;
    regAddr <= 8'h00;
    regWrData <= 8'h00;
    rawValid <= 1'b0;
    rawChan <= 3'h0;
    rawData <= 24'h0;
    outReady <= 1'b0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chkByte("chopDivisor", 8'h20, {2'b00, chopDivisor});
    for (int c = 0; c < 8; c++)
      for (int f = 0; f < 6; f++)
        rd({2'b00, 3'(c), 3'(f)},
           f < 3 ? 8'h00 : 8'h55, "coef");
    rd(8'h40, 8'h00, "ctrl");
    rd(8'h41, 8'h01, "status");
    rd(8'h06, 8'h00, "unmapped");
    rd(8'h80, 8'h00, "unmapped");
    $display("test reset done");
    stream(40);
    $display("test factory stream done");
    // Only high and middle bytes staged: old offset still applies
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h01);
    send(3'h2, 24'h0);
    flush();
    wr(8'h12, 8'h64);
    offM[2] = 24'h000164;
    send(3'h2, 24'h0);
    flush();
    setCoef(3'h3, 1'b0, 24'd100);
    send(3'h3, 24'h0);
    flush();
    setCoef(3'h1, 1'b0, 24'h0000ff);
    setCoef(3'h1, 1'b1, 24'h555575);
    send(3'h1, 24'd1572864);
    flush();
    rd(8'h0d, 8'h75, "gainLow");
    rd(8'h0a, 8'hff, "offLow");
    for (int c = 0; c < 8; c++) begin
      setCoef(3'(c), 1'b0, 24'($urandom_range(4000)) - 24'd2000);
      setCoef(3'(c), 1'b1, 24'h555555 + 24'($urandom_range(4000)) - 24'd2000);
    end
    stream(40);
    $display("test coefficients done");
    wr(8'h40, 8'h01);
    chkByte("chopDivisor", 8'h08, {2'b00, chopDivisor});
    rd(8'h40, 8'h01, "ctrl");
    serialCtrl <= 1'b0;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chkByte("chopDivisor", 8'h20, {2'b00, chopDivisor});
    rd(8'h41, 8'h00, "status");
    wr(8'h40, 8'h00);
    wr(8'h10, 8'h7f);
    rd(8'h10, offM[2][23:16], "offHigh");
    stream(20);
    serialCtrl <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk);
    chkByte("chopDivisor", 8'h08, {2'b00, chopDivisor});
    wr(8'h40, 8'h00);
    chkByte("chopDivisor", 8'h20, {2'b00, chopDivisor});
    $display("test control mode done");
    holdOut = 1'b1;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 9; i++) send(3'(i), 24'($urandom));
    rawValid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chkByte("rawReady", 8'h00, {7'h0, rawReady});
    rd(8'h41, 8'h03, "status");
    holdOut = 1'b0;
    flush();
    chkByte("rawReady", 8'h01, {7'h0, rawReady});
    $display("test buffer done");
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    factory();
    @(posedge ref_clk);
    rd(8'h0d, 8'h55, "gainLow");
    rd(8'h12, 8'h00, "offLow");
    stream(16);
    $display("test second reset done");
    end_of_test();
  end

endmodule : test_channel_offset_gain_calibration

`default_nettype wire
